//--- rtl/rcis_core.sv
// Single-cycle 8-bit instruction core with an AXI4-Lite control slave
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`include "rcis_cfg.svh"
module rcis_core (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [`RCIS_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [`RCIS_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [15:0]                    prog_addr,
	input  wire logic [`RCIS_INSTR_W-1:0]  prog_instr,
	output logic [15:0]                    dmem_addr,
	output logic [7:0]                     dmem_wdata,
	output logic                           dmem_we,
	input  wire logic [7:0]                dmem_rdata
);
	import rcis_pkg::*;

	logic [15:0]      pc_reg;
	logic [15:0]      pc_next;
	logic [7:0]       rf_reg [`RCIS_NREGS];
	logic [7:0]       rf_next [`RCIS_NREGS];
	logic [15:0]      slot_reg [`RCIS_SLOTS];
	logic [15:0]      slot_next [`RCIS_SLOTS];
	logic [15:0]      slot_dn [`RCIS_SLOTS];
	logic [15:0]      slot_up [`RCIS_SLOTS];
	logic             c_reg;
	logic             c_next;
	logic             v_reg;
	logic             v_next;
	logic             z_reg;
	logic             z_next;
	logic             run_reg;
	logic             run_next;
	rcis_op_t         op;
	rcis_form_t       form;
	logic [3:0]       dst;
	logic [3:0]       src;
	logic [7:0]       imm;
	logic [7:0]       opnd;
	logic [7:0]       res;
	logic             res_c;
	logic             res_v;
	logic             wr_acc;
	logic             wr_dst;
	logic             flag_cv;
	logic             take;
	logic [15:0]      pc_inc;
	logic [15:0]      prog_index;
	logic [15:0]      tgt;
	logic [15:0]      push_val;

	assign op         = rcis_op_t'(prog_instr[`RCIS_OP_HI:`RCIS_OP_LO]);
	assign form       = rcis_form_t'(prog_instr[`RCIS_FORM_HI:`RCIS_FORM_LO]);
	assign dst        = prog_instr[`RCIS_DST_HI:`RCIS_DST_LO];
	assign src        = prog_instr[`RCIS_SRC_HI:`RCIS_SRC_LO];
	assign imm        = prog_instr[`RCIS_IMM_HI:`RCIS_IMM_LO];
	assign pc_inc     = pc_reg + 16'h0001;
	assign prog_index = {rf_reg[`RCIS_R_IXH], rf_reg[`RCIS_R_IXL]};
	// Target uses the index value held before this instruction
	assign tgt        = prog_instr[`RCIS_TGT_SEL] ? prog_index : prog_instr[15:0];
	assign push_val   = (op == OP_PUSH) ? prog_index : pc_inc;
	assign prog_addr  = pc_reg;

	// Slot shift; the deepest entry is lost on push and duplicated on pop
	genvar k;
	generate
		for (k = 0; k < `RCIS_SLOTS; k++) begin : g_slot
			if (k == 0) begin : g_top
				assign slot_dn[k] = push_val;
			end else begin : g_deep
				assign slot_dn[k] = slot_reg[k-1];
			end
			if (k == `RCIS_SLOTS - 1) begin : g_last
				assign slot_up[k] = slot_reg[k];
			end else begin : g_mid
				assign slot_up[k] = slot_reg[k+1];
			end
		end
	endgenerate

	// Operand select and data operations
	always_comb begin
		opnd = rf_reg[src];
		if (form == FORM_MEM) begin
			opnd = dmem_rdata;
		end else if (form == FORM_SELF) begin
			opnd = rf_reg[dst];
		end
		res        = opnd;
		res_c      = c_reg;
		res_v      = v_reg;
		wr_acc     = 1'b0;
		wr_dst     = 1'b0;
		flag_cv    = 1'b0;
		dmem_addr  = {rf_reg[`RCIS_R_I0H], rf_reg[`RCIS_R_I0L]} + {8'h00, imm};
		dmem_wdata = rf_reg[dst];
		dmem_we    = 1'b0;
		case (op)
			OP_MOVE_IMM: begin
				res    = imm;
				wr_acc = 1'b1;
				wr_dst = 1'b1;
			end
			OP_MOVE: begin
				wr_acc = 1'b1;
				wr_dst = 1'b1;
			end
			OP_STORE: begin
				dmem_we = run_reg;
			end
			OP_STORE_IMM: begin
				dmem_addr  = {8'h00, imm};
				dmem_wdata = prog_instr[`RCIS_SDATA_HI:`RCIS_SDATA_LO];
				dmem_we    = run_reg;
			end
			OP_CMOVE_CLR: begin
				wr_acc = 1'b1;
				wr_dst = !c_reg;
			end
			OP_CMOVE_SET: begin
				wr_acc = 1'b1;
				wr_dst = c_reg;
			end
			OP_LEFT_SHIFT_ZERO_FILL, OP_LEFT_SHIFT_CARRY_FILL: begin
				res   = {opnd[6:0], (op == OP_LEFT_SHIFT_CARRY_FILL) & c_reg};
				res_c = opnd[7];
				res_v = opnd[7] ^ res[7];
			end
			OP_RIGHT_SHIFT_ZERO_FILL, OP_RIGHT_SHIFT_CARRY_FILL: begin
				res   = {(op == OP_RIGHT_SHIFT_CARRY_FILL) & c_reg, opnd[7:1]};
				res_c = opnd[0];
				res_v = opnd[7] ^ res[7];
			end
			OP_RIGHT_SHIFT_ARITH: begin
				res   = {opnd[7], opnd[7:1]};
				res_c = opnd[0];
				res_v = 1'b0;
			end
			OP_ONES_COMPLEMENT: begin
				res    = ~opnd;
				wr_acc = 1'b1;
				wr_dst = 1'b1;
			end
			OP_TWOS_NEGATE: begin
				res   = ~opnd + 8'h01;
				res_c = (res == 8'h00);
				res_v = opnd[7] & res[7];
			end
			OP_NEGATE_WITH_CARRY: begin
				res   = ~opnd + {7'h00, c_reg};
				res_c = (res == 8'h00) & c_reg;
				res_v = opnd[7] & res[7];
			end
			OP_INC: begin
				res   = opnd + 8'h01;
				res_c = (res == 8'h00);
				res_v = !opnd[7] & res[7];
			end
			OP_INC_CARRY: begin
				res   = opnd + {7'h00, c_reg};
				res_c = (res == 8'h00) & c_reg;
				res_v = !opnd[7] & res[7];
			end
			OP_DEC: begin
				res   = opnd - 8'h01;
				res_c = (res != 8'hff);
				res_v = opnd[7] & !res[7];
			end
			default: begin
			end
		endcase
		if (op >= OP_LEFT_SHIFT_ZERO_FILL && op != OP_ONES_COMPLEMENT) begin
			wr_acc  = 1'b1;
			wr_dst  = 1'b1;
			flag_cv = 1'b1;
		end
	end

	always_comb begin
		case (op)
			OP_JUMP_Z:  take = z_reg;
			OP_JUMP_NZ: take = !z_reg;
			OP_JUMP_C:  take = c_reg;
			OP_JUMP_NC: take = !c_reg;
			OP_JUMP_V:  take = v_reg;
			OP_JUMP_NV: take = !v_reg;
			default:    take = 1'b1;
		endcase
	end

	// Core state; halted core holds every register
	always_comb begin
		pc_next   = pc_reg;
		rf_next   = rf_reg;
		slot_next = slot_reg;
		c_next    = c_reg;
		v_next    = v_reg;
		z_next    = z_reg;
		if (run_reg) begin
			pc_next = pc_inc;
			case (op)
				OP_JUMP, OP_JUMP_Z, OP_JUMP_NZ, OP_JUMP_C, OP_JUMP_NC, OP_JUMP_V,
				OP_JUMP_NV: begin
					if (take) begin
						pc_next = tgt;
					end
				end
				OP_CALL: begin
					slot_next = slot_dn;
					pc_next   = tgt;
				end
				OP_CALL_INDEX: begin
					rf_next[`RCIS_R_IXH] = pc_inc[15:8];
					rf_next[`RCIS_R_IXL] = pc_inc[7:0];
					pc_next              = tgt;
				end
				OP_RET, OP_RETI: begin
					pc_next   = slot_reg[0];
					slot_next = slot_up;
					if (op == OP_RETI) begin
						rf_next[`RCIS_R_STAT][`RCIS_IRQ_EN_BIT] = 1'b1;
					end
				end
				OP_RET_INDEX: begin
					pc_next = prog_index;
				end
				OP_PUSH: begin
					slot_next = slot_dn;
				end
				OP_POP: begin
					rf_next[`RCIS_R_IXH] = slot_reg[0][15:8];
					rf_next[`RCIS_R_IXL] = slot_reg[0][7:0];
					slot_next            = slot_up;
				end
				default: begin
				end
			endcase
			if (wr_acc) begin
				rf_next[`RCIS_R_ACC] = res;
				z_next               = (res == 8'h00);
			end
			if (wr_dst) begin
				rf_next[dst] = res;
			end
			if (flag_cv) begin
				c_next = res_c;
				v_next = res_v;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_reg <= `RCIS_PC_RST;
			for (int i = 0; i < `RCIS_NREGS; i++) begin
				rf_reg[i] <= `RCIS_REG_RST;
			end
			for (int i = 0; i < `RCIS_SLOTS; i++) begin
				slot_reg[i] <= `RCIS_PC_RST;
			end
			c_reg <= 1'b0;
			v_reg <= 1'b0;
			z_reg <= 1'b0;
		end else begin
			pc_reg   <= pc_next;
			rf_reg   <= rf_next;
			slot_reg <= slot_next;
			c_reg    <= c_next;
			v_reg    <= v_next;
			z_reg    <= z_next;
		end
	end

	// AXI4-Lite slave, one write and one read at a time
	logic                     aw_got_reg;
	logic                     aw_got_next;
	logic                     w_got_reg;
	logic                     w_got_next;
	logic [`RCIS_ADDR_W-1:0]  awaddr_reg;
	logic [`RCIS_ADDR_W-1:0]  awaddr_next;
	logic [31:0]              wdata_reg;
	logic [31:0]              wdata_next;
	logic                     wstrb0_reg;
	logic                     wstrb0_next;
	logic                     bvalid_next;
	logic [1:0]               bresp_next;
	logic                     rvalid_next;
	logic [31:0]              rdata_next;
	logic [1:0]               rresp_next;
	logic [`RCIS_ADDR_W-1:0]  wa;
	logic [31:0]              wd;
	logic                     ws;

	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		aw_got_next = aw_got_reg | (s_axi_awvalid & s_axi_awready);
		w_got_next  = w_got_reg | (s_axi_wvalid & s_axi_wready);
		awaddr_next = aw_got_reg ? awaddr_reg : s_axi_awaddr;
		wdata_next  = w_got_reg ? wdata_reg : s_axi_wdata;
		wstrb0_next = w_got_reg ? wstrb0_reg : s_axi_wstrb[0];
		wa          = awaddr_next;
		wd          = wdata_next;
		ws          = wstrb0_next;
		run_next    = run_reg;
		bvalid_next = s_axi_bvalid & !s_axi_bready;
		bresp_next  = s_axi_bresp;
		if (aw_got_next && w_got_next && !s_axi_bvalid) begin
			aw_got_next = 1'b0;
			w_got_next  = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = `RCIS_RESP_OKAY;
			case (wa)
				`RCIS_OFF_CTRL: begin
					if (ws) begin
						run_next = wd[`RCIS_CTRL_RUN];
					end
				end
				`RCIS_OFF_PC, `RCIS_OFF_ACC, `RCIS_OFF_INDEX: begin
				end
				default: bresp_next = `RCIS_RESP_SLVERR;
			endcase
		end
		rvalid_next = s_axi_rvalid & !s_axi_rready;
		rdata_next  = s_axi_rdata;
		rresp_next  = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = `RCIS_RESP_OKAY;
			case (s_axi_araddr)
				`RCIS_OFF_CTRL:  rdata_next = {31'h0, run_reg};
				`RCIS_OFF_PC:    rdata_next = {16'h0, pc_reg};
				`RCIS_OFF_ACC:   rdata_next = {20'h0, rf_reg[`RCIS_R_STAT][`RCIS_IRQ_EN_BIT],
					z_reg, v_reg, c_reg, rf_reg[`RCIS_R_ACC]};
				`RCIS_OFF_INDEX: rdata_next = {slot_reg[0], prog_index};
				default: begin
					rdata_next = 32'h0;
					rresp_next = `RCIS_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			awaddr_reg   <= '0;
			wdata_reg    <= 32'h0;
			wstrb0_reg   <= 1'b0;
			run_reg      <= `RCIS_RUN_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RCIS_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `RCIS_RESP_OKAY;
		end else begin
			aw_got_reg   <= aw_got_next;
			w_got_reg    <= w_got_next;
			awaddr_reg   <= awaddr_next;
			wdata_reg    <= wdata_next;
			wstrb0_reg   <= wstrb0_next;
			run_reg      <= run_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_bresp  <= bresp_next;
			s_axi_rvalid <= rvalid_next;
			s_axi_rdata  <= rdata_next;
			s_axi_rresp  <= rresp_next;
		end
	end

	default clocking dcb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_jump_target: assert property (run_reg && op == OP_JUMP && !prog_instr[`RCIS_TGT_SEL]
		|=> pc_reg == $past(prog_instr[15:0])) else $error("jump target not loaded");
	a_jump_untaken: assert property (run_reg && op == OP_JUMP_Z && !z_reg
		|=> pc_reg == $past(pc_inc) && $stable(rf_reg[`RCIS_R_ACC])) else $error("bad fall-through");
	a_call_link: assert property (run_reg && op == OP_CALL
		|=> slot_reg[0] == $past(pc_inc) && slot_reg[1] == $past(slot_reg[0]))
		else $error("call link wrong");
	a_index_link: assert property (run_reg && op == OP_CALL_INDEX
		|=> prog_index == $past(pc_inc)) else $error("index link wrong");
	a_ret_unwind: assert property (run_reg && op == OP_RET
		|=> pc_reg == $past(slot_reg[0]) && slot_reg[0] == $past(slot_reg[1]))
		else $error("return unwind wrong");
	a_reti_enable: assert property (run_reg && op == OP_RETI
		|=> rf_reg[`RCIS_R_STAT][`RCIS_IRQ_EN_BIT]) else $error("enable bit not set");
	a_push_index: assert property (run_reg && op == OP_PUSH
		|=> slot_reg[0] == $past(prog_index) && pc_reg == $past(pc_inc))
		else $error("push wrong");
	a_pop_index: assert property (run_reg && op == OP_POP
		|=> prog_index == $past(slot_reg[0])) else $error("pop wrong");
	a_cmove_hold: assert property (run_reg && op == OP_CMOVE_CLR && c_reg
		&& dst != `RCIS_R_ACC |=> rf_reg[$past(dst)] == $past(rf_reg[dst]))
		else $error("destination written with carry set");
	a_inc_carry: assert property (run_reg && op == OP_INC
		|=> c_reg == (rf_reg[`RCIS_R_ACC] == 8'h00)) else $error("increment carry wrong");
	a_dec_carry: assert property (run_reg && op == OP_DEC
		|=> c_reg == (rf_reg[`RCIS_R_ACC] != 8'hff)) else $error("decrement carry wrong");
	a_zero_track: assert property (run_reg && wr_acc
		|=> z_reg == (rf_reg[`RCIS_R_ACC] == 8'h00)) else $error("zero flag wrong");
	a_flow_quiet: assert property (run_reg && op inside {[OP_JUMP:OP_POP], OP_STORE,
		OP_STORE_IMM} |=> $stable({c_reg, v_reg, z_reg, rf_reg[`RCIS_R_ACC]}))
		else $error("flags or accumulator disturbed");
	a_step_once: assert property (run_reg && op == OP_MOVE
		|=> pc_reg == $past(pc_inc)) else $error("move took more than one cycle");

	c_call_ret: cover property (run_reg && op == OP_CALL ##1 run_reg && op == OP_RET);
	c_jump_taken: cover property (run_reg && op == OP_JUMP_C && c_reg);
	c_inc_wrap: cover property (run_reg && op == OP_INC && res == 8'h00);
	c_run_write: cover property (s_axi_bvalid && s_axi_bready && run_reg);
endmodule : rcis_core

//--- rtl/rcis_cfg.svh
// Offsets, field positions, reset values and sizes for the instruction core
`ifndef RCIS_CFG_SVH
`define RCIS_CFG_SVH

`define RCIS_ADDR_W       8
`define RCIS_OFF_CTRL     8'h00
`define RCIS_OFF_PC       8'h04
`define RCIS_OFF_ACC      8'h08
`define RCIS_OFF_INDEX    8'h0c
`define RCIS_CTRL_RUN     0
`define RCIS_RUN_RST      1'b0
`define RCIS_PC_RST       16'h0000
`define RCIS_REG_RST      8'h00
`define RCIS_RESP_OKAY    2'b00
`define RCIS_RESP_SLVERR  2'b10

`define RCIS_INSTR_W      22
`define RCIS_OP_HI        21
`define RCIS_OP_LO        17
`define RCIS_TGT_SEL      16
`define RCIS_FORM_HI      15
`define RCIS_FORM_LO      14
`define RCIS_DST_HI       13
`define RCIS_DST_LO       10
`define RCIS_SRC_HI       9
`define RCIS_SRC_LO       6
`define RCIS_IMM_HI       7
`define RCIS_IMM_LO       0
`define RCIS_SDATA_HI     15
`define RCIS_SDATA_LO     8

`define RCIS_NREGS        16
`define RCIS_SLOTS        8
`define RCIS_R_I0H        4'h4
`define RCIS_R_I0L        4'h5
`define RCIS_R_IXH        4'hc
`define RCIS_R_IXL        4'hd
`define RCIS_R_STAT       4'he
`define RCIS_R_ACC        4'hf
`define RCIS_IRQ_EN_BIT   5

`endif

//--- rtl/rcis_pkg.sv
// Opcode and operand-form types of the instruction core
package rcis_pkg;
	typedef enum logic [4:0] {
		OP_NOP = 5'b00000, OP_JUMP = 5'b00001, OP_JUMP_Z = 5'b00010,
		OP_JUMP_NZ = 5'b00011, OP_JUMP_C = 5'b00100, OP_JUMP_NC = 5'b00101,
		OP_JUMP_V = 5'b00110, OP_JUMP_NV = 5'b00111, OP_CALL = 5'b01000,
		OP_CALL_INDEX = 5'b01001, OP_RET = 5'b01010, OP_RET_INDEX = 5'b01011,
		OP_RETI = 5'b01100, OP_PUSH = 5'b01101, OP_POP = 5'b01110,
		OP_MOVE_IMM = 5'b01111, OP_MOVE = 5'b10000, OP_STORE = 5'b10001,
		OP_STORE_IMM = 5'b10010, OP_CMOVE_CLR = 5'b10011, OP_CMOVE_SET = 5'b10100,
		OP_LEFT_SHIFT_ZERO_FILL = 5'b10101, OP_LEFT_SHIFT_CARRY_FILL = 5'b10110,
		OP_RIGHT_SHIFT_ZERO_FILL = 5'b10111, OP_RIGHT_SHIFT_CARRY_FILL = 5'b11000,
		OP_RIGHT_SHIFT_ARITH = 5'b11001, OP_ONES_COMPLEMENT = 5'b11010,
		OP_TWOS_NEGATE = 5'b11011, OP_NEGATE_WITH_CARRY = 5'b11100,
		OP_INC = 5'b11101, OP_INC_CARRY = 5'b11110, OP_DEC = 5'b11111
	} rcis_op_t;

	typedef enum logic [1:0] {
		FORM_PAIR = 2'b00,
		FORM_SELF = 2'b01,
		FORM_MEM  = 2'b10,
		FORM_RSVD = 2'b11
	} rcis_form_t;
endpackage : rcis_pkg

//--- testbench/rcis_mem_model.sv
// Program and data memory on the far side of the core
`timescale 1ns/10ps
module rcis_mem_model (
	input  wire logic        aclk,
	input  wire logic [15:0] prog_addr,
	output logic      [21:0] prog_instr,
	input  wire logic [15:0] dmem_addr,
	input  wire logic [7:0]  dmem_wdata,
	input  wire logic        dmem_we,
	output logic      [7:0]  dmem_rdata
);
	logic [21:0] prog [0:255];
	logic [7:0]  data [0:511];
	assign prog_instr = (prog_addr < 16'h0100) ? prog[prog_addr[7:0]] : 22'h000000;
	// Unbacked addresses follow the address so stale data never looks valid
	assign dmem_rdata = (dmem_addr < 16'h0200) ? data[dmem_addr[8:0]] : ~dmem_addr[7:0];
	always @(posedge aclk) begin
		if (dmem_we && dmem_addr < 16'h0200) begin
			data[dmem_addr[8:0]] <= dmem_wdata;
		end
	end
endmodule : rcis_mem_model

//--- testbench/test_risc_core_instruction_semantics.sv
// Runs programs on the core and on an integer model and compares the state
`timescale 1ns/10ps
`include "rcis_cfg.svh"
module test_risc_core_instruction_semantics;
	import rcis_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] prog_addr, dmem_addr;
	logic [21:0] prog_instr;
	logic [7:0]  dmem_wdata, dmem_rdata;
	logic        dmem_we;
	logic [21:0] img [0:255];
	int          failures = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          seed = 75;
	int          r [16];
	int          sl [8];
	int          mdm [512];
	int          pc, c, v, z;

	rcis_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_addr, .prog_instr,
		.dmem_addr, .dmem_wdata, .dmem_we, .dmem_rdata);
	rcis_mem_model mem (.aclk, .prog_addr, .prog_instr, .dmem_addr, .dmem_wdata,
		.dmem_we, .dmem_rdata);

	always #4 aclk = ~aclk;

	task automatic conclude;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures = failures + 1;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
		logic aw, wd, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			#1;
			aw = s_axi_awvalid && s_axi_awready;
			wd = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid === 1'b1;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		logic ar, rd;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			#1;
			ar = s_axi_arvalid && s_axi_arready;
			rd = s_axi_rvalid === 1'b1;
			dat = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end while (!rd);
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	function automatic logic [21:0] enc(input rcis_op_t op, input logic ts, input int f);
		return {op, ts, f[15:0]};
	endfunction : enc

	task automatic spush(input int val);
		for (int k = 7; k > 0; k--) sl[k] = sl[k - 1];
		sl[0] = val;
	endtask : spush

	task automatic spop;
		for (int k = 0; k < 7; k++) sl[k] = sl[k + 1];
	endtask : spop

	task automatic mstep;
		logic [21:0] w;
		int op, tg, ds, b, a, nx, ix, ea, t;
		w = img[pc];
		op = w[21:17];
		ds = w[13:10];
		ix = r[12] * 256 + r[13];
		tg = w[16] ? ix : w[15:0];
		ea = (r[4] * 256 + r[5] + w[7:0]) & 511;
		b = (w[15:14] == 2'b01) ? r[ds] : (w[15:14] == 2'b10) ? mdm[ea] : r[w[9:6]];
		nx = (pc + 1) & 16'hffff;
		a = -1;
		t = op == OP_JUMP || (op == OP_JUMP_Z && z) || (op == OP_JUMP_NZ && !z)
			|| (op == OP_JUMP_C && c) || (op == OP_JUMP_NC && !c)
			|| (op == OP_JUMP_V && v) || (op == OP_JUMP_NV && !v);
		if (t) nx = tg;
		case (op)
			OP_CALL: begin
				spush(nx);
				nx = tg;
			end
			OP_CALL_INDEX: begin
				r[12] = nx >> 8;
				r[13] = nx & 255;
				nx = tg;
			end
			OP_RET, OP_RETI: begin
				nx = sl[0];
				spop();
				if (op == OP_RETI) r[14] = r[14] | 32;
			end
			OP_RET_INDEX: nx = ix;
			OP_PUSH: spush(ix);
			OP_POP: begin
				r[12] = sl[0] >> 8;
				r[13] = sl[0] & 255;
				spop();
			end
			OP_STORE: mdm[ea] = r[ds];
			OP_STORE_IMM: mdm[w[7:0]] = w[15:8];
			OP_MOVE_IMM: a = w[7:0];
			OP_MOVE, OP_CMOVE_CLR, OP_CMOVE_SET: a = b;
			OP_LEFT_SHIFT_ZERO_FILL, OP_LEFT_SHIFT_CARRY_FILL: begin
				a = ((b << 1) & 255) | (op == OP_LEFT_SHIFT_CARRY_FILL ? c : 0);
				c = b >> 7;
				v = ((a ^ b) >> 7) & 1;
			end
			OP_RIGHT_SHIFT_ZERO_FILL, OP_RIGHT_SHIFT_CARRY_FILL, OP_RIGHT_SHIFT_ARITH: begin
				a = (b >> 1) | (op == OP_RIGHT_SHIFT_ARITH ? b & 128
					: op == OP_RIGHT_SHIFT_CARRY_FILL ? c << 7 : 0);
				c = b & 1;
				v = (op == OP_RIGHT_SHIFT_ARITH) ? 0 : ((a ^ b) >> 7) & 1;
			end
			OP_ONES_COMPLEMENT: a = ~b & 255;
			OP_TWOS_NEGATE, OP_NEGATE_WITH_CARRY: begin
				t = (op == OP_TWOS_NEGATE) ? 1 : c;
				a = (~b + t) & 255;
				c = (a == 0) && t;
				v = (b >> 7) & (a >> 7);
			end
			OP_INC, OP_INC_CARRY: begin
				t = (op == OP_INC) ? 1 : c;
				a = (b + t) & 255;
				c = (a == 0) && t;
				v = !(b >> 7) && (a >> 7);
			end
			OP_DEC: begin
				a = (b - 1) & 255;
				c = a != 255;
				v = (b >> 7) && !(a >> 7);
			end
			default: ;
		endcase
		if (a >= 0) begin
			r[15] = a;
			z = a == 0;
			if (!(op == OP_CMOVE_CLR && c) && !(op == OP_CMOVE_SET && !c)) r[ds] = a;
		end
		pc = nx;
	endtask : mstep

	task automatic run(input string name);
		logic [31:0] d;
		logic [1:0]  rs;
		int          n;
		aresetn <= 1'b0;
		for (n = 0; n < 512; n++) begin
			mdm[n] = $random(seed) & 255;
			mem.data[n] = 8'(mdm[n]);
			if (n < 256) mem.prog[n] = img[n];
		end
		r = '{default: 0};
		sl = '{default: 0};
		pc = 0;
		c = 0;
		v = 0;
		z = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axi_wr(`RCIS_OFF_CTRL, 32'h1, rs);
		for (n = 0; n < 200 && img[pc] !== {OP_JUMP, 1'b0, 16'(pc)}; n++) mstep();
		repeat (n + 8) @(posedge aclk);
		axi_rd(`RCIS_OFF_PC, d, rs);
		chk("pc", d, 32'(pc));
		axi_rd(`RCIS_OFF_ACC, d, rs);
		chk("acc", d, 32'(r[15] | c << 8 | v << 9 | z << 10 | (r[14] & 32) << 6));
		axi_rd(`RCIS_OFF_INDEX, d, rs);
		chk("index", d, 32'(sl[0] << 16 | r[12] << 8 | r[13]));
		for (n = 0; n < 512; n++) chk("dmem", 32'(mem.data[n]), 32'(mdm[n]));
		$display("test %s done", name);
	endtask : run

	initial begin
		logic [31:0] d;
		logic [1:0]  rs;
		int          t, k, op, f;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(`RCIS_OFF_CTRL, d, rs);
		chk("ctrl reset", d, 32'h0);
		axi_rd(`RCIS_OFF_PC, d, rs);
		chk("pc reset", d, 32'(`RCIS_PC_RST));
		img = '{default: 22'h0};
		img[0] = enc(OP_MOVE_IMM, 0, 12 << 10);
		img[1] = enc(OP_MOVE_IMM, 0, 13 << 10 | 10);
		img[2] = enc(OP_CALL, 0, 8);
		img[3] = enc(OP_JUMP_Z, 0, 5);
		img[4] = enc(OP_JUMP_NZ, 0, 6);
		// Plain return right after a call, then a conditional jump through the index
		img[6] = enc(OP_CALL, 0, 18);
		img[7] = enc(OP_JUMP, 0, 14);
		img[8] = enc(OP_PUSH, 0, 0);
		img[9] = enc(OP_CALL, 1, 0);
		img[10] = enc(OP_POP, 0, 0);
		img[11] = enc(OP_POP, 0, 0);
		img[12] = enc(OP_CALL_INDEX, 0, 16);
		img[13] = enc(OP_RETI, 0, 0);
		img[14] = enc(OP_MOVE_IMM, 0, 13 << 10 | 19);
		img[15] = enc(OP_JUMP_NC, 1, 0);
		img[16] = enc(OP_RET_INDEX, 0, 0);
		img[18] = enc(OP_RET, 0, 0);
		img[19] = enc(OP_JUMP, 0, 20);
		// Ten pushes overrun the eight slots, so the pops show what was dropped
		for (k = 0; k < 10; k++) begin
			img[20 + 2 * k] = enc(OP_INC, 0, 1 << 14 | 13 << 10);
			img[21 + 2 * k] = enc(OP_PUSH, 0, 0);
			img[40 + k] = enc(OP_POP, 0, 0);
		end
		img[50] = enc(OP_JUMP, 0, 50);
		run("flow");
		axi_rd(8'h10, d, rs);
		chk("unmapped rdata", d, 32'h0);
		chk("unmapped rresp", rs, `RCIS_RESP_SLVERR);
		axi_wr(8'h10, 32'h1, rs);
		chk("unmapped bresp", rs, `RCIS_RESP_SLVERR);
		axi_wr(`RCIS_OFF_PC, $random(seed), rs);
		chk("pc write bresp", rs, `RCIS_RESP_OKAY);
		axi_rd(`RCIS_OFF_PC, d, rs);
		chk("pc read only", d, 32'd50);
		s_axi_wstrb <= 4'h0;
		axi_wr(`RCIS_OFF_CTRL, 32'h0, rs);
		axi_rd(`RCIS_OFF_CTRL, d, rs);
		chk("ctrl no strobe", d, 32'h1);
		s_axi_wstrb <= 4'hf;
		axi_wr(`RCIS_OFF_CTRL, 32'h0, rs);
		axi_rd(`RCIS_OFF_CTRL, d, rs);
		chk("ctrl cleared", d, 32'h0);
		$display("test register bus done");
		for (t = 0; t < 40; t++) begin
			img = '{default: 22'h0};
			for (k = 0; k < 6; k++) img[k] = enc(OP_MOVE_IMM, 0, (k < 4 ? k : 5) << 10 | (k * 37 + t));
			for (k = 6; k < 26; k++) begin
				op = {$random(seed)} % 32;
				f = $random(seed);
				f[13:12] = 2'b00;
				if (f[9]) f[9:6] = 4'hf;
				else f[9:8] = 2'b00;
				if (op < 8) f = k + 2;
				if (op > 7 && op < 15) op = op + 8;
				img[k] = enc(rcis_op_t'(op), 0, f);
			end
			img[27] = enc(OP_JUMP, 0, 27);
			run("random");
		end
		conclude();
	end
endmodule : test_risc_core_instruction_semantics
